// ---- rtl/comparator_window_monitor.v ----
// comparator pair control, window comparison, single-shot start and wishbone registers
//
// How it works
// - window mode and combined window info exist only while window_pair_enable is set.
// - window_state_field in status shows the pair's window condition only while window mode is active; otherwise it reads as above.
// - window_irq_select picks below, above, into or out-of window as interrupt cause.
// - window event pulses follow inside/outside changes regardless of interrupt mask.
// - each comparator keeps its own output, flag and event during window mode.
// - window plus single-shot mode of the first comparator starts both comparators in the same cycle.
// - writing one to either start_compare_bit launches the joint measurement.
// - a start event for either comparator launches the joint measurement.
`timescale 1ns/1ns
`include "window_monitor_consts.vh"

module comparator_window_monitor (
  input wire clk_sys,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire first_cmp_out,
  input wire first_cmp_valid,
  input wire second_cmp_out,
  input wire second_cmp_valid,
  input wire first_start_event,
  input wire second_start_event,
  output reg first_enable,
  output reg second_enable,
  output reg first_start,
  output reg second_start,
  output reg first_comparator_event,
  output reg second_comparator_event,
  output reg window_inside_event,
  output reg window_outside_event,
  output reg [1:0] window_state_out,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg [1:0] comparator_control_first;
  reg [1:0] comparator_control_second;
  reg [2:0] window_control_reg;
  reg [`IF_WIDTH-1:0] int_flag;
  reg [`IF_WIDTH-1:0] int_mask;
  reg first_result;
  reg second_result;
  reg ack;

  wire window_pair_enable;
  wire [1:0] window_irq_select;
  wire window_active;
  wire first_single;
  wire second_single;
  wire joint_single;

  assign window_pair_enable = window_control_reg[`WC_ENABLE_BIT];
  assign window_irq_select = window_control_reg[`WC_SEL_MSB:`WC_SEL_LSB];
  assign first_single = comparator_control_first[`CC_SINGLE_BIT];
  assign second_single = comparator_control_second[`CC_SINGLE_BIT];
  // window mode needs both comparators running, otherwise there is no pair to combine
  assign window_active = window_pair_enable
                         & comparator_control_first[`CC_ENABLE_BIT]
                         & comparator_control_second[`CC_ENABLE_BIT];
  // both settings agree when software behaves; the first one is taken as the pair's mode
  assign joint_single = window_active & first_single;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for every address

  wire bus_req;
  wire wr_strobe;
  wire rd_strobe;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = ack;
  assign wr_strobe = bus_req & ~ack & wb_we_i & wb_sel_i[0];
  assign rd_strobe = bus_req & ~ack & ~wb_we_i;

  // bus signals are passed in, not read from the module, so that continuous
  // assignments calling this re-evaluate whenever the strobe or address moves
  function is_write;
    input strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      is_write = strobe && (addr == offset);
    end
  endfunction

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  wire [31:0] status_word;
  assign status_word = {27'h0, window_active, window_state_out, second_result, first_result};

  reg [31:0] next_rdata;

  always @* begin
    case (wb_adr_i)
      `OFS_COMPARATOR_CONTROL_FIRST: begin
        next_rdata = {30'h0, comparator_control_first};
      end
      `OFS_COMPARATOR_CONTROL_SECOND: begin
        next_rdata = {30'h0, comparator_control_second};
      end
      `OFS_WINDOW_CONTROL: begin
        next_rdata = {29'h0, window_control_reg};
      end
      `OFS_STATUS: begin
        next_rdata = status_word;
      end
      `OFS_INT_FLAG: begin
        next_rdata = {29'h0, int_flag};
      end
      `OFS_INT_MASK: begin
        next_rdata = {29'h0, int_mask};
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0;
    end else if (rd_strobe) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      comparator_control_first <= `CC_RESET;
      comparator_control_second <= `CC_RESET;
      window_control_reg <= `WC_RESET;
      int_mask <= `IF_RESET;
    end else begin
      if (is_write(wr_strobe, wb_adr_i, `OFS_COMPARATOR_CONTROL_FIRST)) begin
        comparator_control_first <= wb_dat_i[1:0];
      end
      if (is_write(wr_strobe, wb_adr_i, `OFS_COMPARATOR_CONTROL_SECOND)) begin
        comparator_control_second <= wb_dat_i[1:0];
      end
      if (is_write(wr_strobe, wb_adr_i, `OFS_WINDOW_CONTROL)) begin
        window_control_reg <= wb_dat_i[2:0];
      end
      if (is_write(wr_strobe, wb_adr_i, `OFS_INT_MASK)) begin
        int_mask <= wb_dat_i[`IF_WIDTH-1:0];
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_enable <= 1'b0;
      second_enable <= 1'b0;
    end else begin
      first_enable <= comparator_control_first[`CC_ENABLE_BIT];
      second_enable <= comparator_control_second[`CC_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement start

  wire sw_start_first;
  wire sw_start_second;
  wire any_start_request;

  assign sw_start_first = is_write(wr_strobe, wb_adr_i, `OFS_CONTROL_B)
                          & wb_dat_i[`CB_START_FIRST_BIT];
  assign sw_start_second = is_write(wr_strobe, wb_adr_i, `OFS_CONTROL_B)
                           & wb_dat_i[`CB_START_SECOND_BIT];
  assign any_start_request = sw_start_first | sw_start_second
                             | first_start_event | second_start_event;

  // a comparator outside window mode starts only when enabled and set to single-shot
  function solo_start;
    input enable;
    input single;
    input sw_start;
    input start_event;
    begin
      solo_start = enable & single & (sw_start | start_event);
    end
  endfunction

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_start <= 1'b0;
      second_start <= 1'b0;
    end else if (joint_single) begin
      // any source launches both so the two limits are judged on the same sample
      first_start <= any_start_request;
      second_start <= any_start_request;
    end else begin
      // outside window mode each comparator answers only its own sources
      first_start <= solo_start(comparator_control_first[`CC_ENABLE_BIT], first_single,
                                sw_start_first, first_start_event);
      second_start <= solo_start(comparator_control_second[`CC_ENABLE_BIT], second_single,
                                 sw_start_second, second_start_event);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // individual comparator results, events and flags

  wire first_take;
  wire second_take;
  wire first_changed;
  wire second_changed;

  assign first_take = first_cmp_valid & comparator_control_first[`CC_ENABLE_BIT];
  assign second_take = second_cmp_valid & comparator_control_second[`CC_ENABLE_BIT];
  assign first_changed = first_take & (first_cmp_out != first_result);
  assign second_changed = second_take & (second_cmp_out != second_result);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_result <= 1'b0;
      second_result <= 1'b0;
      first_comparator_event <= 1'b0;
      second_comparator_event <= 1'b0;
    end else begin
      // these paths ignore window mode entirely
      if (first_take) begin
        first_result <= first_cmp_out;
      end
      if (second_take) begin
        second_result <= second_cmp_out;
      end
      first_comparator_event <= first_take;
      second_comparator_event <= second_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window tracking

  wire [1:0] pair_state;
  wire pair_primed;
  wire went_above;
  wire went_inside;
  wire went_below;
  wire went_outside;
  wire pair_valid;

  // a pair result is taken whenever either comparator reports, the other one supplying its held result
  assign pair_valid = first_take | second_take;

  window_pair u_window_pair (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .window_on(window_active),
    .result_valid(pair_valid),
    .first_out(first_take ? first_cmp_out : first_result),
    .second_out(second_take ? second_cmp_out : second_result),
    .window_state_field(pair_state),
    .primed(pair_primed),
    .went_above(went_above),
    .went_inside(went_inside),
    .went_below(went_below),
    .went_outside(went_outside)
  );

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      window_state_out <= `WSTATE_ABOVE;
    end else if (window_active && pair_primed) begin
      window_state_out <= pair_state;
    end else if (!window_active) begin
      window_state_out <= `WSTATE_ABOVE;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      window_inside_event <= 1'b0;
      window_outside_event <= 1'b0;
    end else begin
      // independent of int_mask and window_irq_select
      window_inside_event <= went_inside;
      window_outside_event <= went_outside;
    end
  end

  reg window_hit;

  always @* begin
    case (window_irq_select)
      `WSEL_ABOVE: begin
        window_hit = went_above;
      end
      `WSEL_INSIDE: begin
        window_hit = went_inside;
      end
      `WSEL_BELOW: begin
        window_hit = went_below;
      end
      `WSEL_OUTSIDE: begin
        window_hit = went_outside;
      end
      default: begin
        window_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, write one to clear; a set in the clearing cycle wins

  wire [`IF_WIDTH-1:0] flag_set;
  wire [`IF_WIDTH-1:0] flag_clear;

  assign flag_set = {window_hit, second_changed, first_changed};
  assign flag_clear = is_write(wr_strobe, wb_adr_i, `OFS_INT_FLAG)
                      ? wb_dat_i[`IF_WIDTH-1:0] : `IF_RESET;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_flag <= `IF_RESET;
    end else begin
      int_flag <= (int_flag & ~flag_clear) | flag_set;
    end
  end

  assign irq = |(int_flag & int_mask);

endmodule

// ---- rtl/window_monitor_consts.vh ----
// register offsets, field positions and reset values of the comparator window monitor
`ifndef WINDOW_MONITOR_CONSTS_VH
`define WINDOW_MONITOR_CONSTS_VH

// register byte offsets
`define OFS_COMPARATOR_CONTROL_FIRST 8'h00
`define OFS_COMPARATOR_CONTROL_SECOND 8'h04
`define OFS_CONTROL_B 8'h08
`define OFS_WINDOW_CONTROL 8'h0c
`define OFS_STATUS 8'h10
`define OFS_INT_FLAG 8'h14
`define OFS_INT_MASK 8'h18

// comparator_control_reg fields
`define CC_ENABLE_BIT 0
`define CC_SINGLE_BIT 1
`define CC_RESET 2'h0

// control_b_reg fields (write-only strobes)
`define CB_START_FIRST_BIT 0
`define CB_START_SECOND_BIT 1

// window_control_reg fields
`define WC_ENABLE_BIT 0
`define WC_SEL_LSB 1
`define WC_SEL_MSB 2
`define WC_RESET 3'h0

// window_irq_select encodings
`define WSEL_ABOVE 2'h0
`define WSEL_INSIDE 2'h1
`define WSEL_BELOW 2'h2
`define WSEL_OUTSIDE 2'h3

// window_state_field encodings
`define WSTATE_ABOVE 2'h0
`define WSTATE_INSIDE 2'h1
`define WSTATE_BELOW 2'h2

// status register fields
`define ST_FIRST_OUT_BIT 0
`define ST_SECOND_OUT_BIT 1
`define ST_WSTATE_LSB 2
`define ST_WSTATE_MSB 3
`define ST_WINDOW_ACTIVE_BIT 4

// interrupt flag / mask fields
`define IF_FIRST_BIT 0
`define IF_SECOND_BIT 1
`define IF_WINDOW_BIT 2
`define IF_WIDTH 3
`define IF_RESET 3'h0

`endif

// ---- rtl/window_pair.v ----
// window state tracker for one comparator pair: state field and transition pulses
`timescale 1ns/1ns
`include "window_monitor_consts.vh"

module window_pair (
  input wire clk_sys,
  input wire reset_n,
  input wire window_on,
  input wire result_valid,
  input wire first_out,
  input wire second_out,
  output reg [1:0] window_state_field,
  output reg primed,
  output reg went_above,
  output reg went_inside,
  output reg went_below,
  output reg went_outside
);

  reg [1:0] next_state;

  // outputs differing means the input sits between the two limits, in either order
  always @* begin
    if (first_out != second_out) begin
      next_state = `WSTATE_INSIDE;
    end else if (first_out) begin
      next_state = `WSTATE_ABOVE;
    end else begin
      next_state = `WSTATE_BELOW;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      window_state_field <= `WSTATE_ABOVE;
      primed <= 1'b0;
      went_above <= 1'b0;
      went_inside <= 1'b0;
      went_below <= 1'b0;
      went_outside <= 1'b0;
    end else begin
      went_above <= 1'b0;
      went_inside <= 1'b0;
      went_below <= 1'b0;
      went_outside <= 1'b0;
      if (!window_on) begin
        // leaving window mode forgets history so re-entry gives no stale transition
        primed <= 1'b0;
      end else if (result_valid) begin
        window_state_field <= next_state;
        primed <= 1'b1;
        if (primed && next_state != window_state_field) begin
          went_above <= (next_state == `WSTATE_ABOVE);
          went_inside <= (next_state == `WSTATE_INSIDE);
          went_below <= (next_state == `WSTATE_BELOW);
          went_outside <= (window_state_field == `WSTATE_INSIDE);
        end
      end
    end
  end

endmodule

// ---- testbench/comparator_window_monitor_sva.sv ----
// port-level assertions for the comparator window monitor
`timescale 1ns/1ns
module comparator_window_monitor_sva (
  input wire clk_sys,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire first_cmp_valid,
  input wire first_start_event,
  input wire first_enable,
  input wire second_enable,
  input wire first_start,
  input wire second_start,
  input wire first_comparator_event,
  input wire second_cmp_valid,
  input wire second_comparator_event,
  input wire window_inside_event,
  input wire window_outside_event,
  input wire [1:0] window_state_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  reg win_on;
  reg shot;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];
  // shadows taken on the edge the design takes the write
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      win_on <= 1'b0;
      shot <= 1'b0;
    end else if (wr) begin
      win_on <= (wb_adr_i == 8'h0c) ? wb_dat_i[0] : win_on;
      shot <= (wb_adr_i == 8'h00) ? wb_dat_i[1] : shot;
    end
  end
  wire both = win_on && first_enable && second_enable;
  wire joint = both && shot;
  ack_latency_a: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  window_off_a: assert property (!win_on && !$past(win_on) |-> window_state_out == 2'h0)
    else $error("window state while disabled");
  pair_start_a: assert property (both |-> first_start == second_start)
    else $error("window starts not simultaneous");
  soft_start_a: assert property (joint && wr && wb_adr_i == 8'h08 && wb_dat_i[1:0] != 2'h0 |=> first_start && second_start)
    else $error("start bit did not launch both");
  event_start_a: assert property (joint && first_start_event |=> first_start && second_start)
    else $error("start event did not launch both");
  own_event_a: assert property (first_enable && first_cmp_valid |=> first_comparator_event)
    else $error("comparator event missing");
  second_event_a: assert property (second_enable && second_cmp_valid
    |=> second_comparator_event)
    else $error("second comparator event missing");
  inside_event_a: assert property (window_inside_event |-> window_state_out == 2'h1)
    else $error("inside event without inside state");
  outside_event_a: assert property (window_outside_event |-> window_state_out != 2'h1)
    else $error("outside event while inside");
  cover property (window_inside_event);
  cover property (window_outside_event);
  cover property (first_start && second_start);
endmodule

// ---- testbench/comparator_pair_model.sv ----
// behavioural pair of comparators on one shared input with two limits
`timescale 1ns/1ns
module comparator_pair_model #(
  parameter [7:0] LIMIT_HIGH = 8'hc0,
  parameter [7:0] LIMIT_LOW = 8'h40
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] level,
  input wire continuous,
  input wire first_enable,
  input wire second_enable,
  input wire first_start,
  input wire second_start,
  output reg first_cmp_out,
  output reg first_cmp_valid,
  output reg second_cmp_out,
  output reg second_cmp_valid
);
  wire next_first = first_enable && (continuous || first_start);
  wire next_second = second_enable && (continuous || second_start);
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_cmp_out <= 1'b0;
      second_cmp_out <= 1'b0;
      first_cmp_valid <= 1'b0;
      second_cmp_valid <= 1'b0;
    end else begin
      first_cmp_valid <= next_first;
      second_cmp_valid <= next_second;
      // result is not held between measurements, so it toggles
      first_cmp_out <= next_first ? (level > LIMIT_HIGH) : ~first_cmp_out;
      second_cmp_out <= next_second ? (level > LIMIT_LOW) : ~second_cmp_out;
    end
  end
endmodule

// ---- testbench/comparator_window_monitor_test.sv ----
// self-checking bench for the comparator window monitor
`timescale 1ns/1ns
module comparator_window_monitor_test;
  logic clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, continuous;
  logic first_start_event, second_start_event;
  logic [7:0] wb_adr_i, level;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  wire [31:0] wb_dat_o;
  wire [1:0] window_state_out;
  wire wb_ack_o, first_cmp_out, first_cmp_valid, second_cmp_out, second_cmp_valid;
  wire first_enable, second_enable, first_start, second_start, irq;
  wire first_comparator_event, second_comparator_event;
  wire window_inside_event, window_outside_event;
  int bad_count = 0, check_count = 0, pairs = 0, lone = 0, ie = 0, oe = 0;
  comparator_window_monitor dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_cmp_out(first_cmp_out), .first_cmp_valid(first_cmp_valid),
    .second_cmp_out(second_cmp_out), .second_cmp_valid(second_cmp_valid),
    .first_start_event(first_start_event), .second_start_event(second_start_event),
    .first_enable(first_enable), .second_enable(second_enable),
    .first_start(first_start), .second_start(second_start),
    .first_comparator_event(first_comparator_event),
    .second_comparator_event(second_comparator_event),
    .window_inside_event(window_inside_event), .window_outside_event(window_outside_event),
    .window_state_out(window_state_out), .irq(irq));
  comparator_pair_model model_u (.clk_sys(clk_sys), .reset_n(reset_n), .level(level),
    .continuous(continuous), .first_enable(first_enable), .second_enable(second_enable),
    .first_start(first_start), .second_start(second_start),
    .first_cmp_out(first_cmp_out), .first_cmp_valid(first_cmp_valid),
    .second_cmp_out(second_cmp_out), .second_cmp_valid(second_cmp_valid));
  always @(posedge clk_sys) begin
    if (first_start && second_start) pairs++;
    if (first_start != second_start) lone++;
    if (window_inside_event) ie++;
    if (window_outside_event) oe++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask
  task lvl(input logic [7:0] v);
    level <= v;
    repeat (6) @(posedge clk_sys);
  endtask
  task pulse(input logic second);
    first_start_event <= !second;
    second_start_event <= second;
    @(posedge clk_sys);
    first_start_event <= 1'b0;
    second_start_event <= 1'b0;
    lvl(level);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [31:0] q;
    for (int a = 0; a < 32; a += 4)
      rd(a[7:0], 32'h0);
    wb(1'b1, 8'h0c, 32'h1, 4'he, q);
    wr(8'h1c, 32'h7);
    rd(8'h0c, 32'h0);
  endtask
  task t_window;
    logic [7:0] f [4];
    logic [7:0] t [4];
    logic [31:0] e;
    int o;
    f = '{8'h80, 8'h20, 8'h80, 8'h80};
    t = '{8'he0, 8'h80, 8'h20, 8'h20};
    continuous <= 1'b1;
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    chk({30'h0, second_enable, first_enable}, 32'h3);
    lvl(8'he0);
    wr(8'h0c, 32'h1);
    lvl(8'he0);
    rd(8'h10, 32'h13);
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, {29'h0, s[1:0], 1'b1});
      lvl(f[s]);
      wr(8'h14, 32'h7);
      lvl(t[s]);
      e = {29'h0, 1'b1, (f[s] > 8'h40) != (t[s] > 8'h40), (f[s] > 8'hc0) != (t[s] > 8'hc0)};
      rd(8'h14, e);
      wr(8'h14, 32'h7);
      lvl(f[s]);
      rd(8'h14, e & 32'h3);
    end
    wr(8'h18, 32'h4);
    chk({31'h0, irq}, 32'h0);
    o = oe;
    lvl(8'he0);
    chk(oe - o, 32'h1);
    chk({30'h0, window_state_out}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 32'h7);
    chk({31'h0, irq}, 32'h0);
    o = ie;
    wr(8'h18, 32'h0);
    lvl(8'h80);
    chk(ie - o, 32'h1);
    wr(8'h0c, 32'h0);
    o = oe;
    lvl(8'he0);
    rd(8'h10, 32'h3);
    chk(oe - o, 32'h0);
  endtask
  task t_shot;
    int p, l;
    wr(8'h00, 32'h3);
    continuous <= 1'b0;
    wr(8'h04, 32'h3);
    wr(8'h0c, 32'h1);
    lvl(8'h20);
    p = pairs;
    l = lone;
    wr(8'h08, 32'h1);
    lvl(8'h20);
    rd(8'h10, 32'h18);
    lvl(8'he0);
    pulse(1'b0);
    rd(8'h10, 32'h13);
    wr(8'h08, 32'h2);
    pulse(1'b1);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h1);
    lvl(8'he0);
    chk(pairs - p, 32'h4);
    chk(lone - l, 32'h1);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    finish_test;
  end
  initial begin
    reset_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, continuous} = 4'h0;
    {first_start_event, second_start_event} = 2'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    level = 8'h20;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_window;
    t_shot;
    finish_test;
  end
endmodule
bind comparator_window_monitor comparator_window_monitor_sva chk_u (.clk_sys(clk_sys),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .first_cmp_valid(first_cmp_valid), .first_start_event(first_start_event),
  .first_enable(first_enable), .second_enable(second_enable), .first_start(first_start),
  .second_start(second_start), .first_comparator_event(first_comparator_event),
  .second_cmp_valid(second_cmp_valid), .second_comparator_event(second_comparator_event),
  .window_inside_event(window_inside_event), .window_outside_event(window_outside_event),
  .window_state_out(window_state_out));
